// file: dv/addr_ctl_chk.sv
// checker: timing relations between the top module's inputs and outputs
// assumes one clock domain, synchronous active-low reset, bound to addr_output_ctl
`timescale 1ns/1ns
module addr_ctl_chk
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] vprog_adc_i,
    input wire logic rs485_mode_i,
    input wire logic on_req_n_i,
    input wire logic interlock_n_i,
    input wire logic slot_short_i,
    input wire logic slot_res_ok_i,
    input wire logic bus_req_i,
    input wire logic [6:0] bus_addr_i,
    input wire logic bus_read_i,
    input wire logic vcmd_valid_i,
    input wire logic [9:0] vcmd_i,
    input wire logic [6:0] i2c_addr_o,
    input wire logic [3:0] address_select_bits_o,
    input wire logic addr_valid_o,
    input wire logic bus_match_o,
    input wire logic invalid_cmd_o,
    input wire logic output_en_o,
    input wire logic sw_control_o,
    input wire logic sw_intent_o,
    input wire logic [9:0] vset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // a broadcast read is flagged on the next cycle, nothing else is
    a_bcast_read_flag: assert property (bus_req_i && bus_addr_i == 7'h00 && bus_read_i |=> invalid_cmd_o)
        else $error("broadcast read not flagged");
    a_flag_no_cause: assert property (!(bus_req_i && bus_addr_i == 7'h00 && bus_read_i) |=> !invalid_cmd_o)
        else $error("invalid command flagged without a broadcast read");
    // own address in two-wire mode is matched
    a_own_match: assert property (bus_req_i && addr_valid_o && !rs485_mode_i && bus_addr_i == i2c_addr_o |=> bus_match_o)
        else $error("own address not matched");
    a_addr_prefix: assert property (addr_valid_o |-> i2c_addr_o == {3'h4, address_select_bits_o})
        else $error("address is not prefix plus select bits");
    // output gating, allowing for the pin synchronisers
    a_out_on_2w: assert property ((!interlock_n_i && !on_req_n_i && slot_short_i && !rs485_mode_i)[*6] |-> output_en_o)
        else $error("output not on in two-wire mode");
    a_out_on_485: assert property ((rs485_mode_i && slot_res_ok_i && !interlock_n_i)[*6] |-> output_en_o)
        else $error("output not on in rs485 mode");
    a_ilk_off: assert property ($rose(interlock_n_i) ##1 interlock_n_i[*4] |-> !output_en_o)
        else $error("output stays on with interlock released");
    a_req_off: assert property ($rose(on_req_n_i) ##1 (on_req_n_i && !rs485_mode_i)[*4] |-> !output_en_o)
        else $error("output stays on with on request released");
    a_slot_off: assert property ((!slot_short_i && !rs485_mode_i)[*5] |-> !output_en_o)
        else $error("output on without slot short");
    // setpoint ownership
    a_cmd_takes: assert property (vcmd_valid_i |=> sw_control_o && vset_o == $past(vcmd_i))
        else $error("firmware setpoint not applied");
    a_sw_sticky: assert property (sw_control_o |=> sw_control_o)
        else $error("software control dropped");
    a_reset_default: assert property ($rose(nrst_i) |-> vset_o == addr_ctl_pkg::vset_default && !sw_control_o)
        else $error("not default setpoint after reset");
    a_grd_intent: assert property ((vprog_adc_i <= 8'h02)[*5] |-> sw_intent_o)
        else $error("grounded pin not seen as software intent");
    c_bcast_read: cover property (invalid_cmd_o);
    c_out_on: cover property ($rose(output_en_o));
    c_sw_take: cover property ($rose(sw_control_o));
endmodule
bind addr_output_ctl addr_ctl_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .vprog_adc_i(vprog_adc_i),
    .rs485_mode_i(rs485_mode_i), .on_req_n_i(on_req_n_i), .interlock_n_i(interlock_n_i),
    .slot_short_i(slot_short_i), .slot_res_ok_i(slot_res_ok_i), .bus_req_i(bus_req_i),
    .bus_addr_i(bus_addr_i), .bus_read_i(bus_read_i), .vcmd_valid_i(vcmd_valid_i),
    .vcmd_i(vcmd_i), .i2c_addr_o(i2c_addr_o), .address_select_bits_o(address_select_bits_o),
    .addr_valid_o(addr_valid_o), .bus_match_o(bus_match_o), .invalid_cmd_o(invalid_cmd_o),
    .output_en_o(output_en_o), .sw_control_o(sw_control_o), .sw_intent_o(sw_intent_o),
    .vset_o(vset_o));

// file: dv/host_model.sv
// host model: bus engine strobes and firmware setpoint commands
// assumes the bench calls its tasks; drives just after rising edges of clk_i
`timescale 1ns/1ns
module host_model
(
    input wire logic clk_i,
    output logic bus_req_o,
    output logic [6:0] bus_addr_o,
    output logic bus_read_o,
    output logic vcmd_valid_o,
    output logic [9:0] vcmd_o
);
    // idle lines at time zero
    initial
    begin
        bus_req_o = 1'b0;
        bus_addr_o = 7'h7f;
        bus_read_o = 1'b0;
        vcmd_valid_o = 1'b0;
        vcmd_o = 10'h000;
    end
    // one transfer, request taken at the following edge
    task automatic xfer(input logic [6:0] a, input logic rd);
        @(posedge clk_i);
        bus_req_o <= 1'b1;
        bus_addr_o <= a;
        bus_read_o <= rd;
        @(posedge clk_i);
        bus_req_o <= 1'b0;
        bus_addr_o <= ~a; // stale address is not left standing
    endtask
    // broadcast goes out as a write, then the module is read back
    task automatic bcast(input logic [6:0] own);
        xfer(7'h00, 1'b0);
        xfer(own, 1'b1);
    endtask
    // firmware setpoint command, one cycle pulse
    task automatic setv(input logic [9:0] v);
        @(posedge clk_i);
        vcmd_valid_o <= 1'b1;
        vcmd_o <= v;
        @(posedge clk_i);
        vcmd_valid_o <= 1'b0;
        vcmd_o <= ~v;
    endtask
endmodule

// file: dv/test_rectifier_address_output_control.sv
// bench: drives pins and position samples; host model drives bus and setpoint commands
// assumes a 250 MHz clock and synchronous active-low reset
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_rectifier_address_output_control;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] unit_adc, rack_adc, slot_adc, shelf_adc, vprog_adc;
    logic rs485, on_n, ilk_n, s_short, s_res, bus_req, bus_read, vcmd_valid;
    logic [6:0] bus_addr, i2c_addr;
    logic [9:0] vcmd, vset;
    logic [3:0] sel, bay, slot, shelf;
    logic valid, match, inv, out_en, sw_ctl, sw_int, late;
    int mismatches = 0;
    int n_tests = 0;
    // nominal sample codes, 20 mV lsb
    localparam logic [7:0] ucode [10] = '{8'h96, 8'h85, 8'h75, 8'h64, 8'h54, 8'h43, 8'h33,
        8'h22, 8'h12, 8'h00};
    localparam logic [7:0] rcode [8] = '{8'ha5, 8'h8c, 8'h73, 8'h5a, 8'h46, 8'h32, 8'h19, 8'h00};
    // rs485, on_n, ilk_n, short, res, expected enable
    localparam logic [5:0] otab [7] = '{6'b000101, 6'b010100, 6'b001100, 6'b000010,
        6'b110011, 6'b100000, 6'b101010};
    always #2 clk_i = ~clk_i;
    addr_output_ctl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .unit_adc_i(unit_adc),
        .rack_adc_i(rack_adc), .slot_adc_i(slot_adc), .shelf_adc_i(shelf_adc),
        .vprog_adc_i(vprog_adc), .rs485_mode_i(rs485), .on_req_n_i(on_n), .interlock_n_i(ilk_n),
        .slot_short_i(s_short), .slot_res_ok_i(s_res), .bus_req_i(bus_req), .bus_addr_i(bus_addr),
        .bus_read_i(bus_read), .vcmd_valid_i(vcmd_valid), .vcmd_i(vcmd), .i2c_addr_o(i2c_addr),
        .address_select_bits_o(sel), .addr_valid_o(valid), .bay_position_code_o(bay),
        .slot_position_code_o(slot), .shelf_position_code_o(shelf), .bus_match_o(match),
        .invalid_cmd_o(inv), .output_en_o(out_en), .sw_control_o(sw_ctl), .sw_intent_o(sw_int),
        .vset_o(vset), .step_late_o(late));
    host_model u_host (.clk_i(clk_i), .bus_req_o(bus_req), .bus_addr_o(bus_addr),
        .bus_read_o(bus_read), .vcmd_valid_o(vcmd_valid), .vcmd_o(vcmd));
    // expected {valid, select bits} for a unit and rack position
    function automatic logic [4:0] exp_sel(input int u, input int r);
        if (u <= 4 && r <= 4) return {1'b1, 4'((r - 1) * 4 + u - 1)};
        if (u <= 5 && r >= 6) return {1'b1, 4'((r - 6) * 5 + u - 1)};
        if (u >= 6 && u <= 7) return {1'b1, 4'((r - 1) * 2 + u - 6)};
        if (u >= 8 && r >= 4) return {1'b1, 4'((r - 4) * 3 + u - 8)};
        return 5'h00;
    endfunction
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // wait whole cycles, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        wt(2);
        @(posedge clk_i);
        nrst_i <= 1'b1;
    endtask
    // new position samples, then time for sync and decode
    task automatic set_pos(input logic [7:0] u, r, s, h);
        @(posedge clk_i);
        unit_adc <= u;
        rack_adc <= r;
        slot_adc <= s;
        shelf_adc <= h;
        wt(8);
    endtask
    // every unit and rack pair, covered or not
    task automatic t_addr();
        logic [4:0] e;
        for (int u = 1; u <= 10; u++)
        begin
            for (int r = 1; r <= 8; r++)
            begin
                e = exp_sel(u, r);
                set_pos(ucode[u - 1], rcode[r - 1], 8'h00, 8'h14);
                `CHK(valid, e[4])
                if (e[4])
                begin
                    `CHK(sel, e[3:0])
                    `CHK(i2c_addr, {3'h4, e[3:0]})
                end
            end
        end
        set_pos(8'ha5, rcode[0], 8'h00, 8'h14);
        `CHK(valid, 1'b0)
    endtask
    // bay, slot and shelf codes in rs485 mode
    task automatic t_rs485();
        @(posedge clk_i);
        rs485 <= 1'b1;
        for (int k = 1; k <= 10; k++)
        begin
            set_pos(ucode[k - 1], rcode[0], ucode[10 - k], 8'(20 * k));
            `CHK(bay, 4'(k))
            `CHK(slot, 4'(11 - k))
            `CHK(shelf, 4'(k))
        end
        set_pos(ucode[0], rcode[0], 8'ha5, 8'h00);
        `CHK(slot, 4'h0)
        `CHK(shelf, 4'h0)
    endtask
    // output gating table in both modes
    task automatic t_output();
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk_i);
            {rs485, on_n, ilk_n, s_short, s_res} <= otab[i][5:1];
            wt(6);
            `CHK(out_en, otab[i][0])
        end
    endtask
    // broadcast read, broadcast write with read back, foreign address
    task automatic t_bus();
        @(posedge clk_i);
        rs485 <= 1'b0;
        set_pos(ucode[0], rcode[0], 8'h00, 8'h14);
        u_host.xfer(7'h00, 1'b1);
        #1;
        `CHK(inv, 1'b1)
        wt(1);
        `CHK(inv, 1'b0)
        u_host.bcast(7'h40);
        #1;
        `CHK(match, 1'b1)
        `CHK(inv, 1'b0)
        u_host.xfer(7'h41, 1'b1);
        #1;
        `CHK(match, 1'b0)
    endtask
    // pin control, firmware takeover, release by reset
    task automatic t_vprog();
        @(posedge clk_i);
        vprog_adc <= 8'hc8;
        wt(8);
        `CHK(vset, addr_ctl_pkg::vset_default)
        @(posedge clk_i);
        vprog_adc <= 8'h00;
        wt(8);
        `CHK(vset, addr_ctl_pkg::vset_min)
        `CHK(sw_int, 1'b1)
        u_host.setv(10'h1f4);
        #1;
        `CHK(vset, 10'h1f4)
        `CHK(sw_ctl, 1'b1)
        u_host.setv(10'h1fe);
        #1;
        `CHK(vset, 10'h1fe)
        `CHK(late, 1'b0)
        @(posedge clk_i);
        vprog_adc <= 8'hc8;
        wt(8);
        `CHK(vset, 10'h1fe)
        do_reset();
        wt(8);
        `CHK(sw_ctl, 1'b0)
        `CHK(vset, addr_ctl_pkg::vset_default)
    endtask
    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        end_sim();
    end
    initial
    begin
        {unit_adc, rack_adc, slot_adc, shelf_adc, vprog_adc} = {8'h96, 8'ha5, 8'h00, 8'h14, 8'hc8};
        {rs485, on_n, ilk_n, s_short, s_res} = 5'b01100;
        wt(1);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        wt(1);
        `CHK(vset, addr_ctl_pkg::vset_default)
        `CHK(sw_ctl, 1'b0)
        `CHK(out_en, 1'b0)
        t_addr();
        t_rs485();
        t_output();
        t_bus();
        t_vprog();
        end_sim();
    end
endmodule

// file: rtl/addr_ctl_pkg.sv
// package: constants for the position-code decode and output gating block
// assumes position-code voltages arrive as 8-bit adc codes, 0x00 = 0 V, lsb = 20 mV,
// shelf code on its own scale, lsb = 125 mV; setpoints in 100 mV units
// Notes on behaviour
// - two-wire address is 100 plus select bits
// - unit code ladder 3.00 V down to 0 V
// - rack code eight levels 3.3 V to 0 V
// - units 1-4, racks 1-4 map row-major by four
// - units 1-5, racks 6-8 map row-major by five
// - units 6-7, all racks map by two
// - units 8-10, racks 4-8 map by three
// - slot pin to return is second interlock
// - rs485 address is bay, slot, shelf
// - slot code uses unit ladder
// - shelf code windows at 2.5 V steps
// - broadcast read flags invalid command
// - voltage step of 10 V done within 60 ms
// - firmware command latches software control until reset
// - hardware control follows pin, 18 to 53 V
// - pin above 3 V selects default setpoint
// - pin grounded means software control intended
// - after bias reset follow pin again
// - lowest margin level holds 18 V
// - output on only while on-request low in two-wire mode
// - rs485 mode ignores on-request pin
// - output off unless interlock pin connected
package addr_ctl_pkg;
    localparam int clk_mhz = 250; // controller clock rate
    localparam int step_time_ms = 60; // longest time for a setpoint step
    localparam int step_cycles = step_time_ms * clk_mhz * 1000; // rounds down exactly
    localparam int step_max_dv = 100; // 10 V in 100 mV units
    localparam logic [2:0] addr_prefix = 3'h4; // fixed 100 prefix
    localparam logic [6:0] broadcast_addr = 7'h00; // global broadcast address
    // unit/slot ladder: 0.33 V steps, 3.30 V invalid; thresholds halfway in 20 mV lsb
    localparam logic [7:0] ladder_invalid_thr = 8'h9f; // above ~3.15 V is invalid
    localparam logic [7:0] ladder_step = 8'h10; // ~0.33 V per position
    localparam logic [7:0] ladder_half = 8'h08; // half step for rounding
    // rack thresholds, midpoints between levels (20 mV lsb)
    localparam logic [7:0] rack_thr_1 = 8'h99; // between 3.3 V and 2.8 V
    localparam logic [7:0] rack_thr_2 = 8'h80; // between 2.8 V and 2.3 V
    localparam logic [7:0] rack_thr_3 = 8'h67; // between 2.3 V and 1.8 V
    localparam logic [7:0] rack_thr_4 = 8'h50; // between 1.8 V and 1.4 V
    localparam logic [7:0] rack_thr_5 = 8'h3c; // between 1.4 V and 1.0 V
    localparam logic [7:0] rack_thr_6 = 8'h26; // between 1.0 V and 0.5 V
    localparam logic [7:0] rack_thr_7 = 8'h0d; // between 0.5 V and 0 V
    // shelf windows in 125 mV lsb
    localparam logic [7:0] shelf_min [10] = '{8'h12, 8'h25, 8'h3b, 8'h4c, 8'h5e,
        8'h71, 8'h84, 8'h98, 8'haa, 8'hbe};
    localparam logic [7:0] shelf_max [10] = '{8'h15, 8'h2a, 8'h3c, 8'h54, 8'h69,
        8'h7e, 8'h93, 8'ha8, 8'hbc, 8'hd2};
    // setpoints, 100 mV units
    localparam logic [9:0] vset_min = 10'h0b4; // 18.0 V
    localparam logic [9:0] vset_max = 10'h212; // 53.0 V
    localparam logic [9:0] vset_default = 10'h208; // 52.0 V
    localparam logic [7:0] vprog_3v = 8'h96; // 3.00 V at 20 mV lsb
    localparam logic [7:0] vprog_gnd = 8'h02; // at or below this counts as grounded
    typedef enum logic [1:0] {
        ctl_hw = 2'b00,
        ctl_sw = 2'b01
    } ctl_mode_type;
endpackage

// file: rtl/addr_output_ctl.sv
// top: address forming, broadcast check, output gating and setpoint arbitration
// assumes adc codes from another domain; pins asynchronous; bus engine on clk_i
`timescale 1ns/1ns
module addr_output_ctl
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] unit_adc_i, // unit/bay position-code sample
    input wire logic [7:0] rack_adc_i, // rack position-code sample
    input wire logic [7:0] slot_adc_i, // slot position-code sample
    input wire logic [7:0] shelf_adc_i, // shelf position-code sample
    input wire logic [7:0] vprog_adc_i, // programming pin sample
    input wire logic rs485_mode_i, // protocol pin strap: high is rs485
    input wire logic on_req_n_i, // active-low on request pin
    input wire logic interlock_n_i, // low when interlock pin at return
    input wire logic slot_short_i, // slot pin shorted to return
    input wire logic slot_res_ok_i, // slot resistance sensed to return
    input wire logic bus_req_i, // bus engine: addressed transfer start pulse
    input wire logic [6:0] bus_addr_i, // bus engine: 7-bit address
    input wire logic bus_read_i, // bus engine: read bit
    input wire logic vcmd_valid_i, // firmware setpoint command pulse
    input wire logic [9:0] vcmd_i, // firmware setpoint, 100 mV units
    output logic [6:0] i2c_addr_o, // two-wire slave address
    output logic [3:0] address_select_bits_o, // select bits, msb first
    output logic addr_valid_o, // a mapping covers the position
    output logic [3:0] bay_position_code_o, // rs485 bay
    output logic [3:0] slot_position_code_o, // rs485 slot
    output logic [3:0] shelf_position_code_o, // rs485 shelf
    output logic bus_match_o, // transfer is for this device
    output logic invalid_cmd_o, // broadcast read pulse
    output logic output_en_o, // main output on
    output logic sw_control_o, // software owns setpoint
    output logic sw_intent_o, // pin grounded
    output logic [9:0] vset_o, // applied setpoint target
    output logic step_late_o // step exceeded its time budget
);
    // two-stage synchronisers for samples and pins
    logic [7:0] unit_adc_m, unit_adc_q, rack_adc_m, rack_adc_q;
    logic [7:0] slot_adc_m, slot_adc_q, shelf_adc_m, shelf_adc_q;
    logic [7:0] vprog_m, vprog_q;
    logic [4:0] pins_m, pins_q; // mode, on_n, ilk_n, slot short, slot res

    // decoded position codes, fed from the synchronised samples
    pos_code_if codes();

    pos_decode u_dec
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .unit_adc_i(unit_adc_q),
        .rack_adc_i(rack_adc_q),
        .slot_adc_i(slot_adc_q),
        .shelf_adc_i(shelf_adc_q),
        .codes(codes.src)
    );

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            unit_adc_m <= 8'h00;
            unit_adc_q <= 8'h00;
            rack_adc_m <= 8'h00;
            rack_adc_q <= 8'h00;
            slot_adc_m <= 8'h00;
            slot_adc_q <= 8'h00;
            shelf_adc_m <= 8'h00;
            shelf_adc_q <= 8'h00;
            vprog_m <= 8'hff;
            vprog_q <= 8'hff;
            pins_m <= 5'h0c; // pins read as released during reset
            pins_q <= 5'h0c;
        end
        else
        begin
            unit_adc_m <= unit_adc_i;
            unit_adc_q <= unit_adc_m;
            rack_adc_m <= rack_adc_i;
            rack_adc_q <= rack_adc_m;
            slot_adc_m <= slot_adc_i;
            slot_adc_q <= slot_adc_m;
            shelf_adc_m <= shelf_adc_i;
            shelf_adc_q <= shelf_adc_m;
            vprog_m <= vprog_adc_i;
            vprog_q <= vprog_m;
            pins_m <= {rs485_mode_i, on_req_n_i, interlock_n_i, slot_short_i, slot_res_ok_i};
            pins_q <= pins_m;
        end
    end

    logic mode_rs485, on_n, ilk_n, slot_short, slot_res;
    assign {mode_rs485, on_n, ilk_n, slot_short, slot_res} = pins_q;

    // select bits from unit and rack; zero-based indices
    logic [3:0] sel_next;
    logic sel_ok_next;
    logic [3:0] u0, r0;
    always_comb
    begin
        u0 = codes.unit_pos - 4'h1;
        r0 = codes.rack_pos - 4'h1;
        sel_next = 4'h0;
        sel_ok_next = 1'b0;
        if (codes.unit_pos == 4'h0)
            sel_ok_next = 1'b0; // invalid ladder level
        else if (codes.unit_pos <= 4'h4 && codes.rack_pos <= 4'h4)
        begin
            sel_next = 4'((r0 << 2) + u0);
            sel_ok_next = 1'b1;
        end
        else if (codes.unit_pos <= 4'h5 && codes.rack_pos >= 4'h6)
        begin
            sel_next = 4'((codes.rack_pos - 4'h6) * 4'h5 + u0);
            sel_ok_next = 1'b1;
        end
        else if (codes.unit_pos == 4'h6 || codes.unit_pos == 4'h7)
        begin
            sel_next = 4'((r0 << 1) + (codes.unit_pos - 4'h6));
            sel_ok_next = 1'b1;
        end
        else if (codes.unit_pos >= 4'h8 && codes.rack_pos >= 4'h4)
        begin
            sel_next = 4'((codes.rack_pos - 4'h4) * 4'h3 + (codes.unit_pos - 4'h8));
            sel_ok_next = 1'b1;
        end
        else
            sel_ok_next = 1'b0;
    end

    // address state: recomputed every cycle from the decoded codes
    logic [3:0] sel_reg;
    logic sel_ok_reg;
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            sel_reg <= 4'h0;
            sel_ok_reg <= 1'b0;
        end
        else
        begin
            sel_reg <= sel_next;
            sel_ok_reg <= sel_ok_next;
        end
    end

    assign address_select_bits_o = sel_reg;
    assign addr_valid_o = sel_ok_reg;
    assign i2c_addr_o = {addr_ctl_pkg::addr_prefix, sel_reg};
    assign bay_position_code_o = codes.unit_pos;
    assign slot_position_code_o = codes.slot_pos;
    assign shelf_position_code_o = codes.shelf_pos;

    // bus match and broadcast-read check
    logic match_reg, match_next, inv_reg, inv_next;
    logic is_bcast;
    always_comb
    begin
        is_bcast = (bus_addr_i == addr_ctl_pkg::broadcast_addr);
        match_next = bus_req_i && ((sel_ok_reg && bus_addr_i == i2c_addr_o) || is_bcast);
        inv_next = bus_req_i && is_bcast && bus_read_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            match_reg <= 1'b0;
            inv_reg <= 1'b0;
        end
        else
        begin
            match_reg <= match_next;
            inv_reg <= inv_next;
        end
    end

    assign bus_match_o = match_reg;
    assign invalid_cmd_o = inv_reg;

    // output gating
    logic out_reg, out_next;
    always_comb
    begin
        if (mode_rs485)
            out_next = slot_res && !ilk_n;
        else
            out_next = !on_n && !ilk_n && slot_short;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            out_reg <= 1'b0;
        else
            out_reg <= out_next;
    end

    assign output_en_o = out_reg;

    // setpoint arbitration between pin and firmware
    addr_ctl_pkg::ctl_mode_type mode_reg, mode_next;
    logic [9:0] vset_reg, vset_next, hw_vset;
    logic [31:0] step_cnt_reg, step_cnt_next;
    logic late_reg, late_next;
    logic [9:0] dv;
    always_comb
    begin
        // pin map: 0..3 V spans 18..53 V
        if (vprog_q > addr_ctl_pkg::vprog_3v)
            hw_vset = addr_ctl_pkg::vset_default;
        else
            // product needs 16 bits; computed wide so the top of the span does not wrap
            hw_vset = 10'(18'(addr_ctl_pkg::vset_min)
                + (18'(vprog_q) * 18'(addr_ctl_pkg::vset_max - addr_ctl_pkg::vset_min))
                / 18'(addr_ctl_pkg::vprog_3v));
        mode_next = mode_reg;
        vset_next = vset_reg;
        step_cnt_next = (step_cnt_reg != 32'h0) ? step_cnt_reg - 32'h1 : 32'h0;
        late_next = late_reg;
        dv = (vcmd_i > vset_reg) ? vcmd_i - vset_reg : vset_reg - vcmd_i;
        case (mode_reg)
            addr_ctl_pkg::ctl_hw:
            begin
                vset_next = hw_vset;
                if (vcmd_valid_i)
                begin
                    mode_next = addr_ctl_pkg::ctl_sw;
                    vset_next = vcmd_i;
                end
            end
            addr_ctl_pkg::ctl_sw:
            begin
                if (vcmd_valid_i)
                    vset_next = vcmd_i;
            end
            default:
                mode_next = addr_ctl_pkg::ctl_hw;
        endcase
        if (vcmd_valid_i && dv <= 10'(addr_ctl_pkg::step_max_dv))
        begin
            step_cnt_next = 32'(addr_ctl_pkg::step_cycles);
            late_next = 1'b0;
        end
        else if (step_cnt_reg == 32'h1)
            late_next = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            mode_reg <= addr_ctl_pkg::ctl_hw;
            vset_reg <= addr_ctl_pkg::vset_default;
            step_cnt_reg <= 32'h0;
            late_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            vset_reg <= vset_next;
            step_cnt_reg <= step_cnt_next;
            late_reg <= late_next;
        end
    end

    assign sw_control_o = (mode_reg == addr_ctl_pkg::ctl_sw);
    assign sw_intent_o = (vprog_q <= addr_ctl_pkg::vprog_gnd);
    assign vset_o = vset_reg;
    assign step_late_o = late_reg;
endmodule

// file: rtl/pos_code_if.sv
// interface: decoded position codes passed from the decoder to the top
// assumes one clock domain
`timescale 1ns/1ns
interface pos_code_if;
    logic [3:0] unit_pos; // 1..10, 0 invalid
    logic [3:0] rack_pos; // 1..8
    logic [3:0] slot_pos; // 1..10, 0 invalid
    logic [3:0] shelf_pos; // 1..10, 0 invalid
    modport src (output unit_pos, rack_pos, slot_pos, shelf_pos);
    modport dst (input unit_pos, rack_pos, slot_pos, shelf_pos);
endinterface

// file: rtl/pos_decode.sv
// position-code quantiser: turns sampled adc codes into position numbers
// assumes adc codes are already synchronised to clk_i
`timescale 1ns/1ns
module pos_decode
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] unit_adc_i,
    input wire logic [7:0] rack_adc_i,
    input wire logic [7:0] slot_adc_i,
    input wire logic [7:0] shelf_adc_i,
    pos_code_if.src codes
);
    logic [3:0] unit_reg, unit_next;
    logic [3:0] rack_reg, rack_next;
    logic [3:0] slot_reg, slot_next;
    logic [3:0] shelf_reg, shelf_next;

    // ladder decode: nearest 0.33 V step, top reads invalid
    function automatic logic [3:0] ladder(input logic [7:0] v);
        logic [7:0] steps;
        steps = 8'(({1'b0, v} + 9'(addr_ctl_pkg::ladder_half)) / 9'(addr_ctl_pkg::ladder_step));
        if (v > addr_ctl_pkg::ladder_invalid_thr)
            ladder = 4'h0;
        else if (steps > 8'h09)
            ladder = 4'h1;
        else
            ladder = 4'(8'h0a - steps);
    endfunction

    // rack decode: eight levels, 3.3 V is rack 1, 0 V rack 8
    function automatic logic [3:0] rack_dec(input logic [7:0] v);
        // thresholds sit halfway between levels so nominal codes never land on an edge
        if (v >= addr_ctl_pkg::rack_thr_1) rack_dec = 4'h1;        // 3.3
        else if (v >= addr_ctl_pkg::rack_thr_2) rack_dec = 4'h2;   // 2.8
        else if (v >= addr_ctl_pkg::rack_thr_3) rack_dec = 4'h3;   // 2.3
        else if (v >= addr_ctl_pkg::rack_thr_4) rack_dec = 4'h4;   // 1.8
        else if (v >= addr_ctl_pkg::rack_thr_5) rack_dec = 4'h5;   // 1.4
        else if (v >= addr_ctl_pkg::rack_thr_6) rack_dec = 4'h6;   // 1.0
        else if (v >= addr_ctl_pkg::rack_thr_7) rack_dec = 4'h7;   // 0.5
        else rack_dec = 4'h8;                   // 0
    endfunction

    // shelf decode: first window that holds the level, else invalid
    function automatic logic [3:0] shelf_dec(input logic [7:0] v);
        shelf_dec = 4'h0;
        for (int i = 9; i >= 0; i--)
            if (v >= addr_ctl_pkg::shelf_min[i] && v <= addr_ctl_pkg::shelf_max[i])
                shelf_dec = 4'(i + 1);
    endfunction

    // next codes from the current samples
    always_comb
    begin
        unit_next = ladder(unit_adc_i);
        rack_next = rack_dec(rack_adc_i);
        slot_next = ladder(slot_adc_i);
        shelf_next = shelf_dec(shelf_adc_i);
    end

    // register the decoded codes
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            unit_reg <= 4'h0;
            rack_reg <= 4'h1;
            slot_reg <= 4'h0;
            shelf_reg <= 4'h0;
        end
        else
        begin
            unit_reg <= unit_next;
            rack_reg <= rack_next;
            slot_reg <= slot_next;
            shelf_reg <= shelf_next;
        end
    end

    assign codes.unit_pos = unit_reg;
    assign codes.rack_pos = rack_reg;
    assign codes.slot_pos = slot_reg;
    assign codes.shelf_pos = shelf_reg;
endmodule
